/* shared/iorb_defs.vh */
`ifndef IORB_DEFS_VH
`define IORB_DEFS_VH

// Address space of the bank
`define IORB_ADDR_W 6
`define IORB_LAST_ADDR 6'h24
`define IORB_BIT_LAST_ADDR 6'h1f
`define IORB_RESET_VAL 8'h00

// Register offsets
`define IORB_CONV_AUX_CTRL 6'h03
`define IORB_CONV_RES_LOW 6'h04
`define IORB_CONV_RES_HIGH 6'h05
`define IORB_CONV_CTRL_STAT 6'h06
`define IORB_CONV_CHAN_SEL 6'h07
`define IORB_COMP_CTRL_STAT 6'h08
`define IORB_SER_CTRL 6'h0d
`define IORB_SER_STAT 6'h0e
`define IORB_SER_SHIFT 6'h0f
`define IORB_SER_BUFFER 6'h10
`define IORB_SCRATCH0 6'h11
`define IORB_SCRATCH1 6'h12
`define IORB_SCRATCH2 6'h13
`define IORB_DIG_IN_DIS 6'h14
`define IORB_PIN_CHG_MASK 6'h15
`define IORB_PORT_PIN_IN 6'h16
`define IORB_PORT_DIR 6'h17
`define IORB_PORT_OUT 6'h18
`define IORB_NV_CTRL 6'h1c
`define IORB_NV_BYTE 6'h1d
`define IORB_NV_ADDR_LOW 6'h1e
`define IORB_NV_ADDR_HIGH 6'h1f
`define IORB_PWR_RED 6'h20
`define IORB_WDOG_CTRL 6'h21
`define IORB_DBG_DATA 6'h22
`define IORB_DT_PRESCALE 6'h23
`define IORB_DT_CHAN_B 6'h24

// Writable bit masks; reserved bits are left out and read as zero
`define IORB_WM_CONV_AUX 8'he7
`define IORB_WM_CONV_CS 8'hef
`define IORB_WM_COMP_CS 8'hcb
`define IORB_WM_SER_STAT 8'h0f
`define IORB_WM_SIX 8'h3f
`define IORB_WM_NV_AH 8'h01
`define IORB_WM_PWR 8'h0f
`define IORB_WM_WDOG 8'h7f
`define IORB_WM_DT_PS 8'h03
`define IORB_WM_FULL 8'hff

// Write-one-to-clear flag masks
`define IORB_W1C_CONV_CS 8'h10
`define IORB_W1C_COMP_CS 8'h10
`define IORB_W1C_SER_STAT 8'he0
`define IORB_W1C_WDOG 8'h80

// Field positions
`define IORB_BIT_CONV_FLAG 4
`define IORB_BIT_CONV_START 6
`define IORB_BIT_ALIGN_LEFT 5
`define IORB_BIT_COMP_OUT 5
`define IORB_BIT_COMP_FLAG 4
`define IORB_BIT_SER_START 7
`define IORB_BIT_SER_OVF 6
`define IORB_BIT_SER_STOP 5
`define IORB_BIT_SER_COLL 4
`define IORB_BIT_NV_READ 0
`define IORB_BIT_NV_WRITE 1
`define IORB_BIT_WDOG_FLAG 7

`endif

/* rtl/iorb_sync.v */
`timescale 1ns/1ps
`default_nettype none

module iorb_sync #(
  parameter WIDTH = 1
) (
  input wire mclk,
  input wire reset,
  input wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stageOne;
  reg [WIDTH-1:0] stageTwo;

  // First stage feeds only the second, to contain metastability
  always @(posedge mclk) begin
    if (reset) begin
      stageOne <= {WIDTH{1'b0}};
      stageTwo <= {WIDTH{1'b0}};
    end else begin
      stageOne <= asyncIn;
      stageTwo <= stageOne;
    end
  end

  assign syncOut = stageTwo;

endmodule

`default_nettype wire

/* rtl/iorb_bitop.v */
`timescale 1ns/1ps
`default_nettype none

module iorb_bitop (
  input wire [7:0] oldValue,
  input wire [7:0] flagMask,
  input wire [2:0] bitIndex,
  input wire setOp,
  output reg [7:0] mergedData
);

  reg [7:0] target;
  reg [7:0] base;

  // Flags other than the target see zero, so they stay untouched
  always @* begin
    target = 8'h01 << bitIndex;
    base = oldValue & ~flagMask;
    if (setOp) begin
      mergedData = base | target;
    end else begin
      mergedData = base & ~target;
    end
  end

endmodule

`default_nettype wire

/* rtl/iorb_bank.v */
`timescale 1ns/1ps
`default_nettype none
`include "iorb_defs.vh"

////////////////////////////////////////////////////////////////////////////////

// What this block does
// - Registers at 0x00 to 0x1F accept single-bit set and single-bit clear.
// - Bit test on those registers reports whether the core should skip ahead.
// - Bit operations above 0x1F are ignored; those registers take whole bytes only.
// - Some status flags clear on writing one; writing zero leaves them.
// - Single-bit set or clear changes only the addressed bit.
module iorb_bank (
  input wire mclk,
  input wire reset,
  input wire [5:0] ioAddr,
  input wire ioWrite,
  input wire [7:0] ioWdata,
  input wire ioRead,
  input wire setBitOp,
  input wire clearBitOp,
  input wire bitTest,
  input wire skipOnOne,
  input wire [2:0] bitIndex,
  input wire [9:0] convResult,
  input wire convDoneEvt,
  input wire compOutPin,
  input wire compEvt,
  input wire [7:0] serBuffer,
  input wire serCollision,
  input wire serStartEvt,
  input wire serOvfEvt,
  input wire serStopEvt,
  input wire nvDoneEvt,
  input wire wdogEvt,
  input wire [5:0] portPins,
  output reg [7:0] ioRdata,
  output reg readValid,
  output reg skipNext,
  output reg testValid,
  output wire [7:0] convAuxCtrl,
  output wire [7:0] convCtrlStat,
  output wire [7:0] convChanSel,
  output wire [7:0] compCtrlStat,
  output wire [7:0] serCtrl,
  output wire [7:0] serStat,
  output wire [7:0] serShift,
  output wire [7:0] digInDisable,
  output wire [7:0] pinChangeMask,
  output wire [7:0] portDirection,
  output wire [7:0] portOutput,
  output wire [7:0] nvCtrl,
  output wire [7:0] nvByte,
  output wire [15:0] nvAddress,
  output wire [7:0] powerReduction,
  output wire [7:0] wdogCtrl,
  output wire [7:0] debugData,
  output wire [7:0] deadPrescale,
  output wire [7:0] deadChanB
);

  localparam NREG = 37;

  reg [7:0] ioMem [0:NREG-1];
  reg [7:0] next_ioMem [0:NREG-1];
  wire [5:0] pinSync;
  wire compSync;
  reg [7:0] currentValue;
  wire [7:0] bitopData;
  wire inMap;
  wire bitRange;
  wire bitOp;
  wire wrEnable;
  wire [7:0] wrData;
  reg [7:0] convHigh;
  reg [7:0] convLow;
  reg [7:0] evtSet;
  reg [7:0] hwClear;
  reg [7:0] wrBits;
  reg [7:0] newVal;
  integer i;
  integer j;

  ////////////////////////////////////////////////////////////////////////////////

  // Writable bits per address; reserved and read-only addresses give zero
  function [7:0] wrMask;
    input [5:0] addr;
    begin
      case (addr)
        `IORB_CONV_AUX_CTRL: wrMask = `IORB_WM_CONV_AUX;
        `IORB_CONV_CTRL_STAT: wrMask = `IORB_WM_CONV_CS;
        `IORB_CONV_CHAN_SEL: wrMask = `IORB_WM_FULL;
        `IORB_COMP_CTRL_STAT: wrMask = `IORB_WM_COMP_CS;
        `IORB_SER_CTRL: wrMask = `IORB_WM_FULL;
        `IORB_SER_STAT: wrMask = `IORB_WM_SER_STAT;
        `IORB_SER_SHIFT: wrMask = `IORB_WM_FULL;
        `IORB_SCRATCH0: wrMask = `IORB_WM_FULL;
        `IORB_SCRATCH1: wrMask = `IORB_WM_FULL;
        `IORB_SCRATCH2: wrMask = `IORB_WM_FULL;
        `IORB_DIG_IN_DIS: wrMask = `IORB_WM_SIX;
        `IORB_PIN_CHG_MASK: wrMask = `IORB_WM_SIX;
        `IORB_PORT_DIR: wrMask = `IORB_WM_SIX;
        `IORB_PORT_OUT: wrMask = `IORB_WM_SIX;
        `IORB_NV_CTRL: wrMask = `IORB_WM_SIX;
        `IORB_NV_BYTE: wrMask = `IORB_WM_FULL;
        `IORB_NV_ADDR_LOW: wrMask = `IORB_WM_FULL;
        `IORB_NV_ADDR_HIGH: wrMask = `IORB_WM_NV_AH;
        `IORB_PWR_RED: wrMask = `IORB_WM_PWR;
        `IORB_WDOG_CTRL: wrMask = `IORB_WM_WDOG;
        `IORB_DBG_DATA: wrMask = `IORB_WM_FULL;
        `IORB_DT_PRESCALE: wrMask = `IORB_WM_DT_PS;
        `IORB_DT_CHAN_B: wrMask = `IORB_WM_FULL;
        default: wrMask = 8'h00;
      endcase
    end
  endfunction

  // Status flags that clear on writing one
  function [7:0] w1cMask;
    input [5:0] addr;
    begin
      case (addr)
        `IORB_CONV_CTRL_STAT: w1cMask = `IORB_W1C_CONV_CS;
        `IORB_COMP_CTRL_STAT: w1cMask = `IORB_W1C_COMP_CS;
        `IORB_SER_STAT: w1cMask = `IORB_W1C_SER_STAT;
        `IORB_WDOG_CTRL: w1cMask = `IORB_W1C_WDOG;
        default: w1cMask = 8'h00;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////

  iorb_sync #(
    .WIDTH(7)
  ) pinSyncer (
    .mclk(mclk),
    .reset(reset),
    .asyncIn({compOutPin, portPins}),
    .syncOut({compSync, pinSync})
  );

  iorb_bitop bitMerger (
    .oldValue(currentValue),
    .flagMask(w1cMask(ioAddr)),
    .bitIndex(bitIndex),
    .setOp(setBitOp),
    .mergedData(bitopData)
  );

  ////////////////////////////////////////////////////////////////////////////////

  // Converter result alignment follows the left-adjust control bit
  always @* begin
    if (ioMem[`IORB_CONV_CHAN_SEL][`IORB_BIT_ALIGN_LEFT]) begin
      convHigh = convResult[9:2];
      convLow = {convResult[1:0], 6'h00};
    end else begin
      convHigh = {6'h00, convResult[9:8]};
      convLow = convResult[7:0];
    end
  end

  // Value seen by reads and bit tests; inline, as a function would hide the register array from the sensitivity
  always @* begin
    case (ioAddr)
      `IORB_CONV_RES_LOW: currentValue = convLow;
      `IORB_CONV_RES_HIGH: currentValue = convHigh;
      `IORB_COMP_CTRL_STAT:
        currentValue = ioMem[`IORB_COMP_CTRL_STAT] | ({7'h00, compSync} << `IORB_BIT_COMP_OUT);
      `IORB_SER_STAT:
        currentValue = ioMem[`IORB_SER_STAT] | ({7'h00, serCollision} << `IORB_BIT_SER_COLL);
      `IORB_SER_BUFFER: currentValue = serBuffer;
      `IORB_PORT_PIN_IN: currentValue = {2'h0, pinSync};
      default: begin
        if (inMap) begin
          currentValue = ioMem[ioAddr] & (wrMask(ioAddr) | w1cMask(ioAddr));
        end else begin
          currentValue = 8'h00;
        end
      end
    endcase
  end

  assign inMap = (ioAddr <= `IORB_LAST_ADDR);
  assign bitRange = (ioAddr <= `IORB_BIT_LAST_ADDR);
  // Bit operations outside the low range are dropped, not turned into byte writes
  assign bitOp = (setBitOp | clearBitOp) & bitRange;
  assign wrEnable = (ioWrite | bitOp) & inMap;
  assign wrData = bitOp ? bitopData : ioWdata;

  ////////////////////////////////////////////////////////////////////////////////

  // Next state of every stored register
  always @* begin
    for (i = 0; i < NREG; i = i + 1) begin
      evtSet = 8'h00;
      hwClear = 8'h00;
      case (i)
        `IORB_CONV_CTRL_STAT: begin
          evtSet[`IORB_BIT_CONV_FLAG] = convDoneEvt;
          hwClear[`IORB_BIT_CONV_START] = convDoneEvt;
        end
        `IORB_COMP_CTRL_STAT: evtSet[`IORB_BIT_COMP_FLAG] = compEvt;
        `IORB_SER_STAT: begin
          evtSet[`IORB_BIT_SER_START] = serStartEvt;
          evtSet[`IORB_BIT_SER_OVF] = serOvfEvt;
          evtSet[`IORB_BIT_SER_STOP] = serStopEvt;
        end
        // Read strobe lasts one cycle; write strobe ends with the memory
        `IORB_NV_CTRL: begin
          hwClear[`IORB_BIT_NV_READ] = 1'b1;
          hwClear[`IORB_BIT_NV_WRITE] = nvDoneEvt;
        end
        `IORB_WDOG_CTRL: evtSet[`IORB_BIT_WDOG_FLAG] = wdogEvt;
        default: begin
          evtSet = 8'h00;
        end
      endcase
      newVal = ioMem[i] & ~hwClear;
      if (wrEnable && (ioAddr == i[5:0])) begin
        wrBits = wrMask(i[5:0]);
        newVal = (newVal & ~wrBits) | (wrData & wrBits);
        newVal = newVal & ~(wrData & w1cMask(i[5:0]));
      end else begin
        wrBits = 8'h00;
      end
      // A flag event in the same cycle as its clear still lands
      next_ioMem[i] = newVal | evtSet;
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      for (j = 0; j < NREG; j = j + 1) begin
        ioMem[j] <= `IORB_RESET_VAL;
      end
    end else begin
      for (j = 0; j < NREG; j = j + 1) begin
        ioMem[j] <= next_ioMem[j];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Read data and skip decision are registered, one cycle after the request
  always @(posedge mclk) begin
    if (reset) begin
      ioRdata <= 8'h00;
      readValid <= 1'b0;
      skipNext <= 1'b0;
      testValid <= 1'b0;
    end else begin
      readValid <= ioRead;
      if (ioRead) begin
        ioRdata <= currentValue;
      end
      testValid <= bitTest;
      // Tests above the low range never skip
      skipNext <= bitTest & bitRange & (currentValue[bitIndex] == skipOnOne);
    end
  end

  assign convAuxCtrl = ioMem[`IORB_CONV_AUX_CTRL];
  assign convCtrlStat = ioMem[`IORB_CONV_CTRL_STAT];
  assign convChanSel = ioMem[`IORB_CONV_CHAN_SEL];
  assign compCtrlStat = ioMem[`IORB_COMP_CTRL_STAT];
  assign serCtrl = ioMem[`IORB_SER_CTRL];
  assign serStat = ioMem[`IORB_SER_STAT];
  assign serShift = ioMem[`IORB_SER_SHIFT];
  assign digInDisable = ioMem[`IORB_DIG_IN_DIS];
  assign pinChangeMask = ioMem[`IORB_PIN_CHG_MASK];
  assign portDirection = ioMem[`IORB_PORT_DIR];
  assign portOutput = ioMem[`IORB_PORT_OUT];
  assign nvCtrl = ioMem[`IORB_NV_CTRL];
  assign nvByte = ioMem[`IORB_NV_BYTE];
  assign nvAddress = {ioMem[`IORB_NV_ADDR_HIGH], ioMem[`IORB_NV_ADDR_LOW]};
  assign powerReduction = ioMem[`IORB_PWR_RED];
  assign wdogCtrl = ioMem[`IORB_WDOG_CTRL];
  assign debugData = ioMem[`IORB_DBG_DATA];
  assign deadPrescale = ioMem[`IORB_DT_PRESCALE];
  assign deadChanB = ioMem[`IORB_DT_CHAN_B];

endmodule

`default_nettype wire

/* sim/iorb_bank_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module iorb_bank_properties (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [5:0] ioAddr,
  input wire logic ioWrite,
  input wire logic [7:0] ioWdata,
  input wire logic setBitOp,
  input wire logic clearBitOp,
  input wire logic bitTest,
  input wire logic skipOnOne,
  input wire logic [2:0] bitIndex,
  input wire logic serStartEvt,
  input wire logic serOvfEvt,
  input wire logic serStopEvt,
  input wire logic wdogEvt,
  input wire logic skipNext,
  input wire logic testValid,
  input wire logic [7:0] serStat,
  input wire logic [7:0] portDirection,
  input wire logic [7:0] portOutput,
  input wire logic [7:0] wdogCtrl,
  input wire logic [7:0] debugData
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  property p_test_answer;
    bitTest |=> testValid;
  endproperty
  a_test_answer: assert property (p_test_answer) else $error("test answer missing");
  property p_skip_value;
    bitTest && ioAddr == 6'h17 |=> skipNext == ($past(portDirection[bitIndex]) == $past(skipOnOne));
  endproperty
  a_skip_value: assert property (p_skip_value) else $error("skip decision wrong");
  property p_set_bit;
    setBitOp && !ioWrite && ioAddr == 6'h17 |=> portDirection == ($past(portDirection | (8'h01 << bitIndex)) & 8'h3f);
  endproperty
  a_set_bit: assert property (p_set_bit) else $error("bit set wrong");
  property p_clear_bit;
    clearBitOp && !setBitOp && !ioWrite && ioAddr == 6'h18 |=> portOutput == $past(portOutput & ~(8'h01 << bitIndex));
  endproperty
  a_clear_bit: assert property (p_clear_bit) else $error("bit clear wrong");
  property p_high_bitop;
    (setBitOp || clearBitOp) && !ioWrite && ioAddr > 6'h1f |=> $stable(debugData);
  endproperty
  a_high_bitop: assert property (p_high_bitop) else $error("bit op above range took effect");
  property p_high_test;
    bitTest && ioAddr > 6'h1f |=> testValid && !skipNext;
  endproperty
  a_high_test: assert property (p_high_test) else $error("skip above range");
  property p_w1c_byte;
    ioWrite && ioAddr == 6'h21 && !wdogEvt |=> wdogCtrl[7] == ($past(wdogCtrl[7]) && !$past(ioWdata[7]));
  endproperty
  a_w1c_byte: assert property (p_w1c_byte) else $error("flag write wrong");
  // Events in the same cycle may set flags, so they are kept out of the antecedent
  property p_flag_bitop;
    (setBitOp || clearBitOp) && !ioWrite && ioAddr == 6'h0e && !(serStartEvt || serOvfEvt || serStopEvt)
      |=> (serStat & 8'he0) == ($past(serStat & ~({8{setBitOp}} & (8'h01 << bitIndex))) & 8'he0);
  endproperty
  a_flag_bitop: assert property (p_flag_bitop) else $error("other flags disturbed");
  c_flag_set: cover property (setBitOp && ioAddr == 6'h0e);
  c_skip: cover property (skipNext);
  c_high_test: cover property (bitTest && ioAddr > 6'h1f);
endmodule
bind iorb_bank iorb_bank_properties props (.*);
`default_nettype wire

/* sim/iorb_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module iorb_core_model (
  input wire logic mclk,
  input wire logic readValid,
  input wire logic testValid,
  input wire logic skipNext,
  input wire logic [7:0] ioRdata,
  output logic [5:0] ioAddr = 6'h00,
  output logic ioWrite = 1'b0,
  output logic [7:0] ioWdata = 8'h00,
  output logic ioRead = 1'b0,
  output logic setBitOp = 1'b0,
  output logic clearBitOp = 1'b0,
  output logic bitTest = 1'b0,
  output logic skipOnOne = 1'b0,
  output logic [2:0] bitIndex = 3'h0
);
  // Kinds: 0 write, 1 set, 2 clear, 3 read, 4 skip-if-one test, 5 skip-if-zero test
  task automatic issue(input int k, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q, output logic ok);
    int n;
    q = 8'h00;
    ok = 1'b1;
    // Holes in the map are never written
    if (k == 0 && (a < 6'h03 || (a > 6'h08 && a < 6'h0d) || (a > 6'h18 && a < 6'h1c))) return;
    @(posedge mclk);
    ioAddr <= a;
    ioWdata <= d;
    bitIndex <= d[2:0];
    ioWrite <= (k == 0);
    setBitOp <= (k == 1);
    clearBitOp <= (k == 2);
    ioRead <= (k == 3);
    bitTest <= (k > 3);
    skipOnOne <= (k == 4);
    @(posedge mclk);
    {ioWrite, ioRead, setBitOp, clearBitOp, bitTest} <= 5'h00;
    #1;
    if (k > 2) begin
      n = 0;
      while (readValid !== 1'b1 && testValid !== 1'b1 && n < 4) begin
        @(posedge mclk);
        #1;
        n++;
      end
      ok = (n < 4);
      q = (k == 3) ? ioRdata : {7'h00, skipNext};
    end
  endtask
endmodule
`default_nettype wire

/* sim/io_register_bit_access_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module io_register_bit_access_tb;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [9:0] convResult = 10'h000;
  logic [7:0] serBuffer = 8'h00;
  logic [5:0] portPins = 6'h00;
  logic convDoneEvt = 1'b0, compOutPin = 1'b0, compEvt = 1'b0, serCollision = 1'b0, serStartEvt = 1'b0;
  logic serOvfEvt = 1'b0, serStopEvt = 1'b0, nvDoneEvt = 1'b0, wdogEvt = 1'b0;
  wire [5:0] ioAddr;
  wire [2:0] bitIndex;
  wire [7:0] ioWdata, ioRdata, convAuxCtrl, convCtrlStat, convChanSel, compCtrlStat, serCtrl, serStat, serShift;
  wire [7:0] digInDisable, pinChangeMask, portDirection, portOutput, nvCtrl, nvByte, powerReduction, wdogCtrl;
  wire [7:0] debugData, deadPrescale, deadChanB;
  wire [15:0] nvAddress;
  wire ioWrite, ioRead, setBitOp, clearBitOp, bitTest, skipOnOne, readValid, skipNext, testValid;
  localparam logic [5:0] WA [0:5] = '{6'h11, 6'h1d, 6'h22, 6'h17, 6'h20, 6'h23};
  localparam logic [7:0] WM [0:5] = '{8'hff, 8'hff, 8'hff, 8'h3f, 8'h0f, 8'h03};
  logic [7:0] m [0:63];
  int err_count = 0;
  int num_checks = 0;
  int seed = 44659;
  iorb_bank dut (.*);
  iorb_core_model core (.*);
  initial begin
    forever #5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic op(input int k, input logic [5:0] a, input logic [7:0] d, input logic [7:0] e);
    logic [7:0] q;
    logic ok;
    core.issue(k, a, d, q, ok);
    if (ok !== 1'b1) begin
      err_count++;
      $display("mismatch answer at %h expected 1 seen 0", a);
      results();
    end else if (k > 2) begin
      num_checks++;
      if (q !== e) begin
        err_count++;
        $display("mismatch op%0d at %h expected %h seen %h", k, a, e, q);
      end
    end
  endtask
  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, e, s);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int i;
    logic [7:0] d;
    logic [5:0] a;
    logic [2:0] b;
    for (i = 0; i < 64; i++) m[i] = 8'h00;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    // All of the map and one place past it read zero
    for (i = 0; i < 38; i++) op(3, i[5:0], 8'h00, 8'h00);
    for (i = 0; i < 6; i++) begin
      d = 8'($random(seed)) & WM[i];
      m[WA[i]] = d;
      op(0, WA[i], d, 8'h00);
      op(3, WA[i], 8'h00, d);
    end
    op(0, 6'h16, 8'h3f, 8'h00);
    op(3, 6'h16, 8'h00, 8'h00);
    op(0, 6'h1a, 8'hff, 8'h00);
    op(3, 6'h1a, 8'h00, 8'h00);
    for (i = 0; i < 12; i++) begin
      b = 3'($unsigned($random(seed)) % 6);
      a = (i % 2) ? 6'h18 : 6'h17;
      m[a][b] = (i % 3 != 0);
      op((i % 3 != 0) ? 1 : 2, a, {5'h00, b}, 8'h00);
      op(3, a, 8'h00, m[a]);
      op(4, a, {5'h00, b}, {7'h00, m[a][b]});
      op(5, a, {5'h00, b}, {7'h00, ~m[a][b]});
    end
    for (i = 0; i < 8; i++) begin
      op(1, 6'h22, i[7:0], 8'h00);
      op(2, 6'h23, i[7:0], 8'h00);
      op(4 + i % 2, 6'h22, i[7:0], 8'h00);
    end
    op(3, 6'h22, 8'h00, m[6'h22]);
    op(3, 6'h23, 8'h00, m[6'h23]);
    @(posedge mclk);
    {convDoneEvt, compEvt, serStartEvt, serOvfEvt, serStopEvt, wdogEvt} <= 6'h3f;
    @(posedge mclk);
    {convDoneEvt, compEvt, serStartEvt, serOvfEvt, serStopEvt, wdogEvt} <= 6'h00;
    op(3, 6'h0e, 8'h00, 8'he0);
    op(0, 6'h21, 8'h00, 8'h00);
    op(3, 6'h21, 8'h00, 8'h80);
    op(0, 6'h21, 8'h80, 8'h00);
    op(3, 6'h21, 8'h00, 8'h00);
    op(0, 6'h06, 8'h10, 8'h00);
    op(3, 6'h06, 8'h00, 8'h00);
    op(1, 6'h0e, 8'h06, 8'h00);
    op(3, 6'h0e, 8'h00, 8'ha0);
    op(2, 6'h0e, 8'h07, 8'h00);
    op(3, 6'h0e, 8'h00, 8'ha0);
    op(1, 6'h08, 8'h04, 8'h00);
    op(3, 6'h08, 8'h00, 8'h00);
    @(posedge mclk);
    portPins <= 6'($random(seed));
    serBuffer <= 8'($random(seed));
    convResult <= 10'($random(seed));
    compOutPin <= 1'b1;
    serCollision <= 1'b1;
    // Pins pass a two-stage synchroniser before they can be read
    repeat (3) @(posedge mclk);
    op(3, 6'h16, 8'h00, {2'b00, portPins});
    op(3, 6'h10, 8'h00, serBuffer);
    op(3, 6'h04, 8'h00, convResult[7:0]);
    op(3, 6'h05, 8'h00, {6'h00, convResult[9:8]});
    op(3, 6'h08, 8'h00, 8'h20);
    op(3, 6'h0e, 8'h00, 8'hb0);
    // Register outputs follow whole-byte writes, reserved bits kept at zero
    d = 8'($random(seed));
    op(0, 6'h03, d & 8'he7, 8'h00);
    op(0, 6'h0d, ~d, 8'h00);
    op(0, 6'h0f, d, 8'h00);
    op(0, 6'h14, ~d & 8'h3f, 8'h00);
    op(0, 6'h15, d & 8'h3f, 8'h00);
    op(0, 6'h1e, ~d, 8'h00);
    op(0, 6'h1f, d & 8'h01, 8'h00);
    op(0, 6'h24, ~d, 8'h00);
    chk("convAuxCtrl", {8'h00, d & 8'he7}, {8'h00, convAuxCtrl});
    chk("serCtrl", {8'h00, ~d}, {8'h00, serCtrl});
    chk("serShift", {8'h00, d}, {8'h00, serShift});
    chk("digInDisable", {8'h00, ~d & 8'h3f}, {8'h00, digInDisable});
    chk("pinChangeMask", {8'h00, d & 8'h3f}, {8'h00, pinChangeMask});
    chk("nvAddress", {7'h00, d[0], ~d}, nvAddress);
    chk("deadChanB", {8'h00, ~d}, {8'h00, deadChanB});
    chk("nvByte", {8'h00, m[6'h1d]}, {8'h00, nvByte});
    chk("portDirection", {8'h00, m[6'h17]}, {8'h00, portDirection});
    chk("portOutput", {8'h00, m[6'h18]}, {8'h00, portOutput});
    chk("powerReduction", {8'h00, m[6'h20]}, {8'h00, powerReduction});
    chk("debugData", {8'h00, m[6'h22]}, {8'h00, debugData});
    chk("deadPrescale", {8'h00, m[6'h23]}, {8'h00, deadPrescale});
    chk("convCtrlStat", 16'h0000, {8'h00, convCtrlStat});
    chk("compCtrlStat", 16'h0000, {8'h00, compCtrlStat});
    chk("serStat", 16'h00a0, {8'h00, serStat});
    chk("wdogCtrl", 16'h0000, {8'h00, wdogCtrl});
    // Left-adjusted converter result
    op(0, 6'h07, 8'h20, 8'h00);
    chk("convChanSel", 16'h0020, {8'h00, convChanSel});
    op(3, 6'h04, 8'h00, {convResult[1:0], 6'h00});
    op(3, 6'h05, 8'h00, convResult[9:2]);
    // Read strobe drops after one cycle, write strobe on the done event
    op(0, 6'h1c, 8'h03, 8'h00);
    op(3, 6'h1c, 8'h00, 8'h02);
    @(posedge mclk);
    nvDoneEvt <= 1'b1;
    @(posedge mclk);
    nvDoneEvt <= 1'b0;
    op(3, 6'h1c, 8'h00, 8'h00);
    chk("nvCtrl", 16'h0000, {8'h00, nvCtrl});
    results();
  end
endmodule
`default_nettype wire
